/* File: hdl/dipr_defs.svh */
`ifndef DIPR_DEFS_SVH
`define DIPR_DEFS_SVH
// ==========================================================
// Task-file register addresses
`define DIPR_A_DATA 3'h0
`define DIPR_A_FEAT 3'h1
`define DIPR_A_CNT 3'h2
`define DIPR_A_SEC 3'h3
`define DIPR_A_CYLL 3'h4
`define DIPR_A_CYLH 3'h5
`define DIPR_A_DEVHD 3'h6
`define DIPR_A_CMD 3'h7
// ==========================================================
// Command opcodes
`define DIPR_OP_IDLE_A 8'hE3
`define DIPR_OP_IDLE_B 8'h97
`define DIPR_OP_IMM_A 8'hE1
`define DIPR_OP_IMM_B 8'h95
`define DIPR_OP_GEOM 8'h91
`define DIPR_OP_NOP 8'h00
`define DIPR_OP_RDBUF 8'hE4
`define DIPR_OP_WRBUF 8'hE8
`define DIPR_OP_RDDMA 7'h64
// ==========================================================
// Field positions
`define DIPR_DH_LBA 6
`define DIPR_ST_BUSY 7
`define DIPR_ST_READY 6
`define DIPR_ST_DEVICE_FAULT_FLAG 5
`define DIPR_ST_SEEK_COMPLETE_FLAG 4
`define DIPR_ST_DRQ 3
`define DIPR_ST_ERR 0
`define DIPR_ER_UNCORRECTABLE_FLAG 6
`define DIPR_ER_ABORT 2
// ==========================================================
// Reset values and identify layout
`define DIPR_RST_SPT 8'h3F
`define DIPR_RST_HM1 4'hF
`define DIPR_ID_HEADS 8'h37
`define DIPR_ID_SPT 8'h38
`define DIPR_ID_LAST 8'hFF
`define DIPR_ID_SIG 8'hA5
// ==========================================================
// Timing: countdown runs in steps of five seconds
`define DIPR_CLK_HZ 200000000
`define DIPR_STEP_S 5
`define DIPR_MIN_PER_HALFHOUR 30
`define DIPR_SEC_PER_MIN 60
`endif

/* File: hdl/dipr_pkg.sv */
package dipr_pkg;
    // ======================================================
    // Command sequencer states
    typedef enum logic [3:0] {
        ST_READY = 4'b0001,
        ST_MEDIA = 4'b0010,
        ST_DMA = 4'b0100,
        ST_PIO = 4'b1000
    } dipr_mode_t;

    // Power condition reported to the spindle control
    typedef enum logic [2:0] {
        PW_IDLE = 3'b001,
        PW_PERF = 3'b010,
        PW_STBY = 3'b100
    } dipr_pwr_t;

    // Host-written command block
    typedef struct packed {
        logic [7:0] feat;
        logic [7:0] cnt;
        logic [7:0] sec;
        logic [7:0] cyl_lo;
        logic [7:0] cyl_hi;
        logic [7:0] devhd;
    } dipr_tf_t;

    // All state of the block except the sector buffer
    typedef struct packed {
        dipr_mode_t mode;
        dipr_pwr_t pwr;
        dipr_tf_t tf;
        logic busy;
        logic drq;
        logic err;
        logic abort;
        logic uncorrectable_flag;
        logic intrq;
        logic auto_en;
        logic [7:0] tparam;
        logic [12:0] tmr;
        logic [31:0] tick;
        logic [7:0] spt;
        logic [3:0] hm1;
        logic [27:0] lba;
        logic [8:0] left;
        logic [7:0] widx;
        logic wrbuf;
        logic [15:0] rdata;
        logic [15:0] ddata;
        logic dmarq;
        logic media_req;
        logic spinup;
        logic qabort;
        logic [7:0] idsum;
        logic [15:0] idword;
    } dipr_state_t;
endpackage

/* File: hdl/dipr_top.sv */
// Overview of operation
// [R1] Idle command loads and starts standby countdown
// [R2] Idle entry spins up unless already spinning
// [R3] Countdown value zero disables automatic standby
// [R4] Countdown value decoded into five-second steps
// [R5] Expiry enters standby; host access restarts countdown
// [R6] Immediate idle keeps stored countdown value
// [R7] Geometry command sets sectors, heads; identify shows
// [R8] Geometry kept until reload, reset, or revert
// [R9] Zero sectors per track means none
// [R10] Host keeps heads and cylinder count in range
// [R11] No-operation always aborts with error status
// [R12] Feature zero aborts queue; others keep it
// [R13] No-operation leaves address registers untouched
// [R14] Buffer read sends one sector, word-wide
// [R15] Buffer read returns whatever last landed in the shared buffer, buffer-written or media-filled
// [R16] DMA read moves media sectors word-wide
// [R17] Each DMA word paced by request, host acknowledge
// [R18] One interrupt per DMA read, at the end
// [R19] Uncorrectable media error stops at failing sector
// [R20] Sector count zero means 256 sectors
// [R21] Start address taken as CHS or LBA
// [R22] Identify last word: checksum high, signature low
`include "dipr_defs.svh"

module dipr_top #(
    parameter int unsigned STEP_CYCLES = `DIPR_STEP_S * `DIPR_CLK_HZ,
    parameter int WORDS = 256
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic srst_i,
    input wire logic revert_i,
    // Task-file register port
    input wire logic hw_i,
    input wire logic hr_i,
    input wire logic [2:0] ha_i,
    input wire logic [15:0] hd_i,
    output logic [15:0] hq_o,
    output logic intrq_o,
    // DMA handshake
    output logic dmarq_o,
    input wire logic dmack_i,
    output logic [15:0] dd_o,
    // Media side
    output logic media_req_o,
    output logic [27:0] media_lba_o,
    input wire logic media_vld_i,
    input wire logic [15:0] media_data_i,
    input wire logic media_end_i,
    input wire logic media_err_i,
    // Spindle and queue control
    input wire logic spinning_i,
    output logic spinup_o,
    output dipr_pkg::dipr_pwr_t pwr_o,
    output logic qabort_o,
    // Identify data port
    input wire logic id_rd_i,
    input wire logic [7:0] id_idx_i,
    input wire logic [15:0] id_rom_i,
    output logic [15:0] id_word_o
);
    // ======================================================
    // Helpers
    // Countdown value to five-second steps
    function automatic logic [12:0] steps(input logic [7:0] v);
        logic [12:0] r;
        r = 13'h0000;
        if (v <= 8'd240)
            r = {5'h00, v}; // R4
        else if (v <= 8'd251)
            r = 13'((v - 8'd240) * `DIPR_MIN_PER_HALFHOUR
                * `DIPR_SEC_PER_MIN / `DIPR_STEP_S); // R4
        else if (v == 8'd253)
            r = 13'(8 * 60 * `DIPR_SEC_PER_MIN / `DIPR_STEP_S); // R4
        else
            r = {5'h00, v}; // R4
        return r;
    endfunction

    // CHS start address into a linear sector number
    function automatic logic [27:0] chs_lba(input dipr_pkg::dipr_tf_t t,
        input logic [7:0] spt, input logic [3:0] hm1);
        logic [39:0] c;
        c = {24'h000000, t.cyl_hi, t.cyl_lo} * ({36'h0, hm1} + 40'h1);
        c = (c + {36'h0, t.devhd[3:0]}) * {32'h0, spt};
        c = c + {32'h0, t.sec} - 40'h1;
        return c[27:0];
    endfunction

    // ======================================================
    // State
    dipr_pkg::dipr_state_t s_q;
    dipr_pkg::dipr_state_t s_d;
    logic [15:0] sbuf [WORDS];
    logic cmd_wr;
    logic [7:0] cmd;
    logic access;
    logic [7:0] nidx;

    assign cmd = hd_i[7:0];
    assign cmd_wr = hw_i && ha_i == `DIPR_A_CMD
        && s_q.mode == dipr_pkg::ST_READY;
    assign access = hw_i || hr_i;

    // Sector buffer: shared by media fill and buffer write, so a
    // buffer read returns whatever last landed there
    always_ff @(posedge clk_i)
    begin
        if (s_q.mode == dipr_pkg::ST_MEDIA && media_vld_i)
            sbuf[s_q.widx] <= media_data_i; // R15
        else if (s_q.wrbuf && hw_i && ha_i == `DIPR_A_DATA)
            sbuf[s_q.widx] <= hd_i; // R15
    end

    // ======================================================
    // Next-state logic
    always_comb
    begin
        s_d = s_q;
        s_d.media_req = 1'b0;
        s_d.qabort = 1'b0;
        nidx = s_q.widx + 8'h01;
        // Standby countdown; only a real host access restarts it
        s_d.tick = (s_q.tick == STEP_CYCLES - 1) ? 32'h0 : s_q.tick + 32'h1;
        if (access)
        begin
            s_d.tmr = steps(s_q.tparam); // R5
            s_d.tick = 32'h0; // R5
        end
        else if (s_q.auto_en && s_q.pwr != dipr_pkg::PW_STBY
            && s_q.tick == STEP_CYCLES - 1)
        begin
            s_d.tmr = s_q.tmr - 13'h0001;
            if (s_q.tmr == 13'h0001)
            begin
                s_d.pwr = dipr_pkg::PW_STBY; // R5
                s_d.spinup = 1'b0;
            end
        end
        if (s_q.spinup && spinning_i)
            s_d.spinup = 1'b0;
        // Host register writes while ready
        if (hw_i && s_q.mode == dipr_pkg::ST_READY)
        begin
            case (ha_i)
                `DIPR_A_FEAT: s_d.tf.feat = hd_i[7:0];
                `DIPR_A_CNT: s_d.tf.cnt = hd_i[7:0];
                `DIPR_A_SEC: s_d.tf.sec = hd_i[7:0];
                `DIPR_A_CYLL: s_d.tf.cyl_lo = hd_i[7:0];
                `DIPR_A_CYLH: s_d.tf.cyl_hi = hd_i[7:0];
                `DIPR_A_DEVHD: s_d.tf.devhd = hd_i[7:0];
                default: ;
            endcase
        end
        // Host register reads; status read drops the interrupt
        if (hr_i)
        begin
            case (ha_i)
                `DIPR_A_DATA:
                begin
                    s_d.rdata = sbuf[s_q.widx];
                    if (s_q.mode == dipr_pkg::ST_PIO)
                    begin
                        s_d.widx = nidx; // R14
                        if (nidx == 8'h00)
                        begin
                            s_d.mode = dipr_pkg::ST_READY;
                            s_d.drq = 1'b0;
                        end
                    end
                end
                `DIPR_A_FEAT: s_d.rdata = {8'h00, 1'b0, s_q.uncorrectable_flag, 3'b000,
                    s_q.abort, 2'b00};
                `DIPR_A_CNT: s_d.rdata = {8'h00, s_q.tf.cnt};
                `DIPR_A_SEC: s_d.rdata = {8'h00, s_q.tf.sec};
                `DIPR_A_CYLL: s_d.rdata = {8'h00, s_q.tf.cyl_lo};
                `DIPR_A_CYLH: s_d.rdata = {8'h00, s_q.tf.cyl_hi};
                `DIPR_A_DEVHD: s_d.rdata = {8'h00, s_q.tf.devhd};
                default:
                begin
                    s_d.rdata = {8'h00, s_q.busy, !s_q.busy, 1'b0,
                        1'b1, s_q.drq, 2'b00, s_q.err};
                    s_d.intrq = 1'b0;
                end
            endcase
        end
        // Buffer write: one sector from the host into the buffer
        if (s_q.wrbuf && hw_i && ha_i == `DIPR_A_DATA)
        begin
            s_d.widx = nidx;
            if (nidx == 8'h00)
            begin
                s_d.wrbuf = 1'b0;
                s_d.drq = 1'b0;
                s_d.intrq = 1'b1;
            end
        end
        // Command decode
        if (cmd_wr && !s_q.wrbuf)
        begin
            s_d.err = 1'b0;
            s_d.abort = 1'b0;
            s_d.uncorrectable_flag = 1'b0;
            s_d.intrq = 1'b1;
            if (cmd == `DIPR_OP_IDLE_A || cmd == `DIPR_OP_IDLE_B)
            begin
                s_d.pwr = dipr_pkg::PW_IDLE; // R1
                s_d.tparam = s_q.tf.cnt; // R1
                s_d.tmr = steps(s_q.tf.cnt); // R1 R4
                s_d.tick = 32'h0; // R1
                s_d.auto_en = s_q.tf.cnt != 8'h00; // R3
                s_d.spinup = !spinning_i; // R2
            end
            else if (cmd == `DIPR_OP_IMM_A || cmd == `DIPR_OP_IMM_B)
            begin
                s_d.pwr = dipr_pkg::PW_PERF; // R6
                s_d.spinup = !spinning_i; // R2
            end
            else if (cmd == `DIPR_OP_GEOM)
            begin
                s_d.spt = s_q.tf.cnt; // R7 R9
                s_d.hm1 = s_q.tf.devhd[3:0]; // R7
            end
            else if (cmd == `DIPR_OP_NOP)
            begin
                s_d.err = 1'b1; // R11
                s_d.abort = 1'b1; // R11
                s_d.qabort = s_q.tf.feat == 8'h00; // R12
            end
            else if (cmd == `DIPR_OP_RDBUF)
            begin
                s_d.intrq = 1'b1;
                s_d.mode = dipr_pkg::ST_PIO; // R14
                s_d.drq = 1'b1;
                s_d.widx = 8'h00; // R15
            end
            else if (cmd == `DIPR_OP_WRBUF)
            begin
                s_d.intrq = 1'b0;
                s_d.wrbuf = 1'b1;
                s_d.drq = 1'b1;
                s_d.widx = 8'h00;
            end
            else if (cmd[7:1] == `DIPR_OP_RDDMA)
            begin
                s_d.intrq = 1'b0; // R18
                s_d.busy = 1'b1;
                s_d.mode = dipr_pkg::ST_MEDIA; // R16
                s_d.media_req = 1'b1;
                s_d.widx = 8'h00;
                s_d.left = (s_q.tf.cnt == 8'h00) ? 9'h100
                    : {1'b0, s_q.tf.cnt}; // R20
                s_d.lba = s_q.tf.devhd[`DIPR_DH_LBA]
                    ? {s_q.tf.devhd[3:0], s_q.tf.cyl_hi, s_q.tf.cyl_lo,
                       s_q.tf.sec} // R21
                    : chs_lba(s_q.tf, s_q.spt, s_q.hm1); // R21
            end
            else
            begin
                s_d.err = 1'b1;
                s_d.abort = 1'b1;
            end
        end
        // DMA read sequencer
        case (s_q.mode)
            dipr_pkg::ST_MEDIA:
            begin
                if (media_err_i)
                begin
                    s_d.mode = dipr_pkg::ST_READY; // R19
                    s_d.busy = 1'b0;
                    s_d.err = 1'b1;
                    s_d.uncorrectable_flag = 1'b1; // R19
                    s_d.intrq = 1'b1; // R18
                    s_d.tf.cnt = s_q.left[7:0];
                end
                else if (media_vld_i)
                    s_d.widx = nidx;
                else if (media_end_i)
                begin
                    s_d.mode = dipr_pkg::ST_DMA;
                    s_d.widx = 8'h00;
                    s_d.ddata = sbuf[0];
                    s_d.dmarq = 1'b1; // R17
                end
            end
            dipr_pkg::ST_DMA:
            begin
                if (dmack_i && s_q.dmarq)
                begin
                    s_d.widx = nidx; // R17
                    s_d.ddata = sbuf[nidx];
                    if (nidx == 8'h00)
                    begin
                        s_d.dmarq = 1'b0;
                        s_d.left = s_q.left - 9'h001;
                        s_d.lba = s_q.lba + 28'h1;
                        if (s_q.left == 9'h001)
                        begin
                            s_d.mode = dipr_pkg::ST_READY;
                            s_d.busy = 1'b0;
                            s_d.intrq = 1'b1; // R18
                            s_d.tf.cnt = 8'h00;
                        end
                        else
                        begin
                            s_d.mode = dipr_pkg::ST_MEDIA;
                            s_d.media_req = 1'b1;
                        end
                    end
                end
            end
            default: ;
        endcase
        // Identify stream: heads and sectors live, then checksum
        if (id_rd_i)
        begin
            s_d.idword = id_rom_i;
            if (id_idx_i == `DIPR_ID_HEADS)
                s_d.idword = {11'h000, {1'b0, s_q.hm1} + 5'h01}; // R7
            else if (id_idx_i == `DIPR_ID_SPT)
                s_d.idword = {8'h00, s_q.spt}; // R7
            if (id_idx_i == `DIPR_ID_LAST)
                s_d.idword = {8'h00 - s_q.idsum - `DIPR_ID_SIG,
                    `DIPR_ID_SIG}; // R22
            s_d.idsum = ((id_idx_i == 8'h00) ? 8'h00 : s_q.idsum)
                + s_d.idword[15:8] + s_d.idword[7:0]; // R22
        end
        // Soft reset and revert drop the geometry back to default
        if (srst_i || revert_i)
        begin
            s_d.spt = `DIPR_RST_SPT; // R8
            s_d.hm1 = `DIPR_RST_HM1; // R8
        end
    end

    // ======================================================
    // State register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_q <= '0;
            s_q.mode <= dipr_pkg::ST_READY;
            s_q.pwr <= dipr_pkg::PW_IDLE;
            s_q.spt <= `DIPR_RST_SPT; // R8
            s_q.hm1 <= `DIPR_RST_HM1; // R8
        end
        else
            s_q <= s_d;
    end

    assign hq_o = s_q.rdata;
    assign intrq_o = s_q.intrq;
    assign dmarq_o = s_q.dmarq;
    assign dd_o = s_q.ddata;
    assign media_req_o = s_q.media_req;
    assign media_lba_o = s_q.lba;
    assign spinup_o = s_q.spinup;
    assign pwr_o = s_q.pwr;
    assign qabort_o = s_q.qabort;
    assign id_word_o = s_q.idword;

    // ======================================================
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i || srst_i || revert_i);

    sequence nop_issued;
        cmd_wr && !s_q.wrbuf && cmd == `DIPR_OP_NOP;
    endsequence
    sequence last_word;
        s_q.mode == dipr_pkg::ST_DMA && dmack_i && dmarq_o
            && s_q.widx == 8'hFF && s_q.left == 9'h001;
    endsequence

    a_idle_load: assert property (cmd_wr && !s_q.wrbuf // R1
        && cmd == `DIPR_OP_IDLE_A && s_q.tf.cnt == 8'd253
        |=> s_q.auto_en && s_q.tmr == 13'd5760)
        else $error("idle countdown not loaded");
    a_zero_off: assert property (cmd_wr && !s_q.wrbuf // R3
        && cmd == `DIPR_OP_IDLE_B && s_q.tf.cnt == 8'h00
        |=> !s_q.auto_en)
        else $error("zero countdown left automatic standby on");
    a_expire_stby: assert property (s_q.auto_en && s_q.tmr == 13'h0001 // R5
        && s_q.tick == STEP_CYCLES - 1 && !access && !cmd_wr
        && pwr_o != dipr_pkg::PW_STBY |=> pwr_o == dipr_pkg::PW_STBY)
        else $error("countdown expiry missed standby");
    a_imm_keep: assert property (cmd_wr && !s_q.wrbuf // R6
        && (cmd == `DIPR_OP_IMM_A || cmd == `DIPR_OP_IMM_B)
        |=> $stable(s_q.tparam) && pwr_o == dipr_pkg::PW_PERF)
        else $error("immediate idle disturbed countdown value");
    a_geom_load: assert property (cmd_wr && !s_q.wrbuf // R7
        && cmd == `DIPR_OP_GEOM |=> s_q.spt == $past(s_q.tf.cnt)
        && s_q.hm1 == $past(s_q.tf.devhd[3:0]))
        else $error("geometry not taken");
    a_nop_abort: assert property (nop_issued |=> s_q.err // R11 R12
        && s_q.abort && intrq_o
        && qabort_o == ($past(s_q.tf.feat) == 8'h00))
        else $error("no-operation did not abort correctly");
    a_nop_regs: assert property (nop_issued |=> $stable(s_q.tf.cnt) // R13
        && $stable(s_q.tf.sec) && $stable(s_q.tf.devhd))
        else $error("no-operation changed address registers");
    a_dma_irq: assert property (last_word |=> intrq_o && !dmarq_o // R18
        ##1 !dmarq_o)
        else $error("DMA read end without interrupt");
    a_dma_quiet: assert property (s_q.mode != dipr_pkg::ST_READY // R18
        && s_q.busy |-> !intrq_o)
        else $error("interrupt raised mid transfer");
    a_unc_stop: assert property (s_q.mode == dipr_pkg::ST_MEDIA // R19
        && media_err_i |=> (!dmarq_o && s_q.uncorrectable_flag && intrq_o) [*2])
        else $error("media error did not stop transfer");
endmodule

/* File: verif/dipr_media_model.sv */
// ==========================================================
// Media side: answers each fetch with one sector of words
module dipr_media_model (
    // Clock
    input wire logic clk_i,
    // Fetch request from the device
    input wire logic req_i,
    input wire logic [27:0] lba_i,
    input wire logic [27:0] bad_lba_i,
    // Sector stream back to the device
    output logic vld_o,
    output logic [15:0] data_o,
    output logic end_o,
    output logic err_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [27:0] cur;
    initial
    begin
        vld_o = 1'b0;
        data_o = 16'h0000;
        end_o = 1'b0;
        err_o = 1'b0;
    end
    // One sector per request; the flagged address fails part way
    always @(negedge clk_i)
    begin
        if (req_i)
        begin
            cur = lba_i;
            repeat (3) @(negedge clk_i);
            for (int i = 0; i < 256; i++)
            begin
                if (cur == bad_lba_i && i == 10)
                    break;
                vld_o = 1'b1;
                data_o = cur[15:0] + 16'(i) * 16'h0101;
                @(negedge clk_i);
            end
            vld_o = 1'b0;
            data_o = ~data_o; // Stale word must not look valid
            if (cur == bad_lba_i)
                err_o = 1'b1;
            else
                end_o = 1'b1;
            @(negedge clk_i);
            err_o = 1'b0;
            end_o = 1'b0;
        end
    end
endmodule

/* File: verif/tb_disk_idle_param_read_cmds.sv */
`include "dipr_defs.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
    err_total++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end

module tb_disk_idle_param_read_cmds;
    timeunit 1ns;
    timeprecision 1ps;
    // ======================================================
    // Stimulus and observed signals
    logic clk_i = 0, rst_i = 1, srst_i = 0, revert_i = 0;
    logic hw_i = 0, hr_i = 0, dmack_i = 0, spinning_i = 0, id_rd_i = 0;
    logic [2:0] ha_i = 0;
    logic [15:0] hd_i = 0, id_rom_i = 0, hq_o, dd_o, id_word_o, q, mdat;
    logic [7:0] id_idx_i = 0, spt, sum;
    logic [27:0] media_lba_o, bad_lba = 28'hFFFFFFF;
    logic intrq_o, dmarq_o, media_req_o, spinup_o, qabort_o;
    logic mvld, mend, merr, irq_q = 1'b0;
    logic [3:0] hm1;
    dipr_pkg::dipr_pwr_t pwr_o;
    int err_total = 0, total_checks = 0, cyc = 0, irqs = 0, irq0 = 0;
    logic [7:0] tf [2:6];

    dipr_top #(.STEP_CYCLES(4), .WORDS(256)) u_dut (.clk_i(clk_i),
        .rst_i(rst_i), .srst_i(srst_i), .revert_i(revert_i), .hw_i(hw_i),
        .hr_i(hr_i), .ha_i(ha_i), .hd_i(hd_i), .hq_o(hq_o),
        .intrq_o(intrq_o), .dmarq_o(dmarq_o), .dmack_i(dmack_i),
        .dd_o(dd_o), .media_req_o(media_req_o), .media_lba_o(media_lba_o),
        .media_vld_i(mvld), .media_data_i(mdat), .media_end_i(mend),
        .media_err_i(merr), .spinning_i(spinning_i), .spinup_o(spinup_o),
        .pwr_o(pwr_o), .qabort_o(qabort_o), .id_rd_i(id_rd_i),
        .id_idx_i(id_idx_i), .id_rom_i(id_rom_i), .id_word_o(id_word_o));
    dipr_media_model u_media (.clk_i(clk_i), .req_i(media_req_o),
        .lba_i(media_lba_o), .bad_lba_i(bad_lba), .vld_o(mvld),
        .data_o(mdat), .end_o(mend), .err_o(merr));

    // Clock, cycle limit and interrupt edge count
    always #2.5 clk_i = ~clk_i;
    always @(negedge clk_i)
    begin
        cyc++;
        if (intrq_o && !irq_q)
            irqs++;
        irq_q <= intrq_o;
        if (cyc == 40000)
        begin
            err_total++;
            stop_test();
        end
    end

    // ======================================================
    // Host register cycles, one strobe cycle with a gap after
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(negedge clk_i);
        {hw_i, ha_i, hd_i} = {1'b1, a, d};
        @(negedge clk_i);
        hw_i = 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [15:0] d);
        @(negedge clk_i);
        {hr_i, ha_i} = {1'b1, a};
        @(negedge clk_i);
        hr_i = 1'b0;
        d = hq_o;
    endtask
    task automatic idw(input logic [7:0] i, output logic [15:0] d);
        @(negedge clk_i);
        {id_rd_i, id_idx_i, id_rom_i} = {1'b1, i, 16'($urandom)};
        d = (i == `DIPR_ID_HEADS) ? 16'(hm1) + 16'h0001 :
            (i == `DIPR_ID_SPT) ? {8'h00, spt} : id_rom_i;
        @(negedge clk_i);
        id_rd_i = 1'b0;
    endtask
    // Sequential pass: geometry words and closing checksum word
    task automatic id_pass();
        logic [15:0] e;
        sum = 8'h00;
        for (int i = 0; i < 255; i++)
        begin
            idw(8'(i), e);
            `CHK(id_word_o, e)
            sum = sum + e[15:8] + e[7:0];
        end
        idw(`DIPR_ID_LAST, e);
        `CHK(id_word_o, {8'h00 - sum - `DIPR_ID_SIG, `DIPR_ID_SIG})
    endtask
    // Host DMA channel: moves a word only while the request stands
    task automatic dma(input logic [27:0] l0, input int n);
        int k;
        for (int s = 0; s < n; s++)
            for (int w = 0; w < 256; w++)
            begin
                k = 0;
                while (!dmarq_o && k < 3000)
                begin
                    @(negedge clk_i);
                    k++;
                end
                `CHK(dd_o, 16'(l0 + 28'(s)) + 16'(w) * 16'h0101)
                dmack_i = 1'b1;
                @(negedge clk_i);
                dmack_i = 1'b0;
                repeat (1 + $urandom % 2) @(negedge clk_i);
            end
    endtask
    task automatic idle(input logic [7:0] n, input int wait1, wait2,
        input dipr_pkg::dipr_pwr_t p1);
        wr(`DIPR_A_CNT, 16'(n));
        wr(`DIPR_A_CMD, (n == 8'h00) ? 16'(`DIPR_OP_IDLE_B)
            : 16'(`DIPR_OP_IDLE_A));
        `CHK(pwr_o, dipr_pkg::PW_IDLE)
        `CHK(spinup_o, !spinning_i)
        repeat (wait1) @(negedge clk_i);
        `CHK(pwr_o, dipr_pkg::PW_IDLE)
        repeat (wait2) @(negedge clk_i);
        `CHK(pwr_o, p1)
    endtask
    task automatic stop_test();
        if (err_total == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ======================================================
    // Main sequence
    initial
    begin
        void'($urandom(32'h4a5fd90d));
        repeat (4) @(negedge clk_i);
        rst_i = 1'b0;
        `CHK(pwr_o, dipr_pkg::PW_IDLE)
        // No-operation with queue abort and without
        for (int f = 0; f < 2; f++)
        begin
            for (int a = 2; a <= 6; a++)
            begin
                tf[a] = 8'($urandom);
                wr(3'(a), {8'h00, tf[a]});
            end
            wr(`DIPR_A_FEAT, (f == 0) ? 16'h0000 : 16'($urandom % 255 + 1));
            wr(`DIPR_A_CMD, 16'(`DIPR_OP_NOP));
            `CHK(qabort_o, f == 0)
            rd(`DIPR_A_FEAT, q);
            `CHK(q[`DIPR_ER_ABORT], 1'b1)
            rd(`DIPR_A_CMD, q);
            `CHK(q[`DIPR_ST_ERR], 1'b1)
            for (int a = 2; a <= 6; a++)
            begin
                rd(3'(a), q);
                `CHK(q[7:0], tf[a])
            end
        end
        // Geometry: default, random, zero sectors, then resets
        {spt, hm1} = {`DIPR_RST_SPT, `DIPR_RST_HM1};
        id_pass();
        for (int g = 0; g < 2; g++)
        begin
            spt = (g == 0) ? 8'($urandom) : 8'h00;
            hm1 = 4'($urandom);
            wr(`DIPR_A_CNT, {8'h00, spt});
            wr(`DIPR_A_DEVHD, {12'h00A, hm1});
            wr(`DIPR_A_CMD, 16'(`DIPR_OP_GEOM));
            id_pass();
            @(negedge clk_i);
            if (g == 0) srst_i = 1'b1; else revert_i = 1'b1;
            @(negedge clk_i);
            {srst_i, revert_i} = 2'b00;
            {spt, hm1} = {`DIPR_RST_SPT, `DIPR_RST_HM1};
            id_pass();
        end
        // Buffer write then buffer read of the same words
        wr(`DIPR_A_CMD, 16'(`DIPR_OP_WRBUF));
        for (int i = 0; i < 256; i++)
            wr(`DIPR_A_DATA, 16'(i) * 16'h3B1 ^ 16'hC35A);
        wr(`DIPR_A_CMD, 16'(`DIPR_OP_RDBUF));
        for (int i = 0; i < 256; i++)
        begin
            rd(`DIPR_A_DATA, q);
            `CHK(q, 16'(i) * 16'h3B1 ^ 16'hC35A)
        end
        rd(`DIPR_A_CMD, q);
        // DMA read: LBA two sectors, CHS one sector, then media fault
        for (int t = 0; t < 3; t++)
        begin
            tf[3] = 8'($urandom);
            tf[4] = 8'($urandom % 4);
            tf[6] = (t == 1) ? 8'hA2 : 8'hE0;
            bad_lba = (t == 2) ? {4'h0, 8'h00, tf[4], tf[3]} + 28'h1 : '1;
            for (int a = 3; a <= 6; a++)
                wr(3'(a), {8'h00, (a == 5) ? 8'h00 : tf[a]});
            wr(`DIPR_A_CNT, (t == 0) ? 16'h0002 : (t == 1) ? 16'h1 : 16'h3);
            irq0 = irqs;
            wr(`DIPR_A_CMD, (t == 1) ? 16'h00C9 : 16'h00C8);
            dma((t == 1) ? (28'(tf[4]) * 16 + 2) * 63 + 28'(tf[3]) - 1 :
                {12'h000, tf[4], tf[3]}, (t == 0) ? 2 : 1);
            repeat (300) @(negedge clk_i);
            `CHK(irqs - irq0, 1)
            rd(`DIPR_A_CNT, q);
            `CHK(q[7:0], (t == 2) ? 8'h02 : 8'h00)
            rd(`DIPR_A_FEAT, q);
            `CHK(q[`DIPR_ER_UNCORRECTABLE_FLAG], t == 2)
            rd(`DIPR_A_CMD, q);
        end
        // Idle countdown: short, disabled, long, restarted
        idle(8'd10, 30, 20, dipr_pkg::PW_STBY);
        wr(`DIPR_A_CMD, 16'(`DIPR_OP_IMM_B));
        `CHK(pwr_o, dipr_pkg::PW_PERF)
        `CHK(spinup_o, 1'b1)
        idle(8'd0, 100, 100, dipr_pkg::PW_IDLE);
        spinning_i = 1'b1;
        idle(8'd241, 1400, 80, dipr_pkg::PW_STBY);
        `CHK(spinup_o, 1'b0)
        idle(8'd253, 1, 1, dipr_pkg::PW_IDLE);
        idle(8'd10, 1, 1, dipr_pkg::PW_IDLE);
        repeat (26) @(negedge clk_i);
        rd(`DIPR_A_CMD, q);
        repeat (30) @(negedge clk_i);
        `CHK(pwr_o, dipr_pkg::PW_IDLE)
        repeat (20) @(negedge clk_i);
        `CHK(pwr_o, dipr_pkg::PW_STBY)
        stop_test();
    end
endmodule
